// [dv/fbcw_asserts.sv]
// port checker for the command word interpreter
// assumes it is bound to fbcw_top, single clock domain
`timescale 1ns/1ps
module fbcw_chk
(
  input wire        clk,
  input wire        sys_rst,
  input wire        cw_valid,
  input wire [15:0] drive_command_word,
  input wire        control_place_is_bus,
  input wire        motor_zero_speed,
  input wire        fault_in,
  input wire        warning_in,
  input wire [15:0] drive_state_word,
  input wire        run_cmd_q,
  input wire [1:0]  ramp_mode_q,
  input wire        jog1_sel_q,
  input wire        jog2_sel_q,
  input wire        fault_ack_q
);
  // ****************************************
  // sequences
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // four quiet cycles let the three-edge pipeline settle
  sequence quiet4;
    (!cw_valid) [*4];
  endsequence
  sequence bus_word;
    cw_valid && control_place_is_bus && drive_command_word[10];
  endsequence
  // ****************************************
  // properties
  // ****************************************
  spare_zero_a: assert property (drive_state_word[14:11] == 4'h0)
    else $error("spare state bits set");
  hb_echo_a: assert property (bus_word ##1 quiet4 |->
    drive_state_word[15] == $past(drive_command_word[11], 4))
    else $error("heartbeat echo wrong");
  ack_pulse_a: assert property (fault_ack_q |=> !fault_ack_q)
    else $error("ack pulse too long");
  jog_excl_a: assert property (!(jog1_sel_q && jog2_sel_q))
    else $error("both jog refs selected");
  coast_inh_a: assert property ((bus_word and !drive_command_word[1]) ##1 quiet4 |->
    drive_state_word[6] && !drive_state_word[4])
    else $error("coast stop not reported");
  qstop_rep_a: assert property ((bus_word and drive_command_word[2:1] == 2'h1) ##1 quiet4
    |-> !drive_state_word[5])
    else $error("quick stop not reported");
  ramp_zero_a: assert property ((bus_word and (drive_command_word[3:0] == 4'hF
    && !drive_command_word[4] && drive_command_word[6:5] != 2'h0 && motor_zero_speed
    && drive_state_word[1])) ##1 quiet4 |-> ramp_mode_q == 2'h1)
    else $error("ramp output not zeroed");
  fault_rep_a: assert property (fault_in |-> ##[1:4] drive_state_word[3])
    else $error("fault not reported");
  warn_rep_a: assert property (warning_in [*4] |-> drive_state_word[7])
    else $error("warning not reported");
  bus_idle_a: assert property ((!control_place_is_bus) [*4] |-> !drive_state_word[9])
    else $error("bus control shown active");
  rst_val_a: assert property ($fell(sys_rst) |->
    drive_state_word == 16'h0040 && !run_cmd_q)
    else $error("reset values wrong");
endmodule // fbcw_chk

// [dv/fbcw_master.sv]
// fieldbus master model: sends command words as one-cycle strobes
// assumes calls start just after a rising edge
`timescale 1ns/1ps
module fbcw_master
(
  input  wire        clk,
  output reg         cw_valid,
  output reg  [15:0] drive_command_word,
  output reg         hb_q
);
  initial
  begin
    cw_valid = 1'b0;
    drive_command_word = 16'h0000;
    hb_q = 1'b0;
  end
  // heartbeat flips with every word; lines go stale once the strobe drops
  task send(input [15:0] w);
    begin
      hb_q = ~hb_q;
      drive_command_word = {w[15:12], hb_q, w[10:0]};
      cw_valid = 1'b1;
      @(posedge clk);
      #1;
      cw_valid = 1'b0;
      drive_command_word = ~drive_command_word;
    end
  endtask
endmodule // fbcw_master

// [dv/tb.sv]
// self-checking bench for fbcw_top with a master model
// assumes the checker and master files are compiled first
`timescale 1ns/1ps
module tb;
  logic        clk = 0;
  logic        sys_rst = 1;
  wire         cw_valid;
  wire  [15:0] drive_command_word;
  wire         hb_q;
  logic [15:0] heartbeat_timeout_setting = 16'h0000;
  logic        control_place_is_bus = 1, aux_jog_enable = 1, jog_enable_din = 0;
  logic        io_jog1 = 0, io_jog2 = 0, motor_zero_speed = 1, modulating = 0;
  logic        fault_in = 0, fault_removed_voltage = 1, warning_in = 0;
  logic        speed_at_ref = 0, fout_above_fmax = 0;
  wire  [15:0] drive_state_word;
  wire  [1:0]  stop_kind_q, ramp_mode_q;
  wire         run_cmd_q, jog1_sel_q, jog2_sel_q, fault_ack_q;
  int          err_total = 0;
  int          checks_done = 0;
  int          n;
  logic [15:0] wt [5] = '{16'h046F, 16'h045F, 16'h043F, 16'h044F, 16'h041F};
  logic [1:0]  rt [5] = '{2'h1, 2'h2, 2'h3, 2'h1, 2'h2};
  always #2 clk = ~clk;
  fbcw_master i_mst
  (
    .clk (clk), .cw_valid (cw_valid), .drive_command_word (drive_command_word), .hb_q (hb_q)
  );
  fbcw_top i_dut
  (
    .clk (clk), .sys_rst (sys_rst), .cw_valid (cw_valid),
    .drive_command_word (drive_command_word),
    .heartbeat_timeout_setting (heartbeat_timeout_setting),
    .control_place_is_bus (control_place_is_bus), .aux_jog_enable (aux_jog_enable),
    .jog_enable_din (jog_enable_din), .io_jog1 (io_jog1), .io_jog2 (io_jog2),
    .motor_zero_speed (motor_zero_speed), .modulating (modulating), .fault_in (fault_in),
    .fault_removed_voltage (fault_removed_voltage), .warning_in (warning_in),
    .speed_at_ref (speed_at_ref), .fout_above_fmax (fout_above_fmax),
    .drive_state_word (drive_state_word), .run_cmd_q (run_cmd_q),
    .stop_kind_q (stop_kind_q), .ramp_mode_q (ramp_mode_q), .jog1_sel_q (jog1_sel_q),
    .jog2_sel_q (jog2_sel_q), .fault_ack_q (fault_ack_q)
  );
  // ****************************************
  // helpers
  // ****************************************
  task tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task chk(input [15:0] exp, input [15:0] got, input string nm);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task snd(input [15:0] w);
    i_mst.send(w);
    tick(6);
  endtask
  task wrap_up;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task t_on;
    // a coast stop first, so every pass starts from the inhibit state
    snd(16'h0404);
    snd(16'h0406);
    chk(16'h0040, drive_state_word & 16'h0040, "inhibit");
    snd(16'h0407);
    chk(16'h0232, drive_state_word & 16'h0272, "ready_op");
  endtask
  task t_ramp;
    modulating = 1;
    snd(16'h047F);
    chk(16'h1, run_cmd_q, "run");
    chk(16'h0004, drive_state_word & 16'h0004, "running");
    for (int i = 0; i < 5; i++)
    begin
      snd(wt[i]);
      chk(rt[i], ramp_mode_q, "ramp_mode");
    end
    snd(16'h057F);
    chk(16'h0, jog1_sel_q, "jog_in_run");
    snd(16'h0476);
    chk(16'h1, stop_kind_q, "stop_kind");
    chk(16'h0001, drive_state_word & 16'h0041, "ready_on");
  endtask
  task t_jog;
    snd(16'h0507);
    chk(16'h1, jog1_sel_q, "jog1");
    snd(16'h0707);
    chk(16'h0, {jog1_sel_q, jog2_sel_q}, "jog_both");
    snd(16'h0607);
    chk(16'h1, jog2_sel_q, "jog2");
    aux_jog_enable = 0;
    snd(16'h0507);
    chk(16'h0, jog1_sel_q, "jog1_off");
    aux_jog_enable = 1;
    motor_zero_speed = 0;
    snd(16'h040F);
    chk(16'h0, run_cmd_q, "busjog_moving");
    motor_zero_speed = 1;
    snd(16'h040F);
    chk(16'h1, run_cmd_q, "busjog");
    motor_zero_speed = 0;
    snd(16'h0467);
    chk(16'h0, ramp_mode_q, "ramp_after_jog");
    motor_zero_speed = 1;
    tick(6);
    chk(16'h1, ramp_mode_q, "ramp_at_rest");
  endtask
  task t_stops;
    snd(16'h047F);
    snd(16'h047B);
    chk(16'h3, stop_kind_q, "quick_kind");
    snd(16'h0479);
    chk(16'h2, stop_kind_q, "coast_kind");
    chk(16'h0040, drive_state_word & 16'h0050, "coast_state");
  endtask
  task t_fault;
    fault_in = 1;
    warning_in = 1;
    speed_at_ref = 1;
    fout_above_fmax = 1;
    tick(6);
    chk(16'h0588, drive_state_word & 16'h0588, "fault_warn");
    fault_in = 0;
    warning_in = 0;
    speed_at_ref = 0;
    fout_above_fmax = 0;
    i_mst.send(16'h0487);
    n = 0;
    repeat (6)
    begin
      tick(1);
      n += fault_ack_q;
    end
    chk(16'h1, n[15:0], "ack_pulses");
    chk(16'h0040, drive_state_word & 16'h0048, "after_ack");
  endtask
  task t_bus;
    snd(16'h047F);
    snd(16'h007F);
    chk(16'h0040, drive_state_word & 16'h0240, "bus_off");
    chk(16'h2, stop_kind_q, "bus_off_kind");
    repeat (2)
    begin
      snd(16'hFC06);
      chk({hb_q, 15'h0}, drive_state_word & 16'hF800, "echo");
    end
    control_place_is_bus = 0;
    tick(400);
    chk(16'h0, drive_state_word & 16'h0208, "idle_fault");
    // io jog works whatever the control place, but only once enabled
    io_jog1 = 1;
    tick(6);
    chk(16'h0, run_cmd_q, "iojog_locked");
    jog_enable_din = 1;
    tick(6);
    chk(16'h3, {run_cmd_q, jog1_sel_q}, "iojog");
    io_jog2 = 1;
    tick(6);
    chk(16'h0, {run_cmd_q, jog1_sel_q, jog2_sel_q}, "iojog_both");
    jog_enable_din = 0;
    io_jog1 = 0;
    io_jog2 = 0;
  endtask
  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial
  begin
    tick(8);
    sys_rst = 0;
    chk(16'h0040, drive_state_word, "reset_state");
    t_on();
    t_ramp();
    t_on();
    t_jog();
    t_stops();
    t_on();
    t_fault();
    t_on();
    t_bus();
    wrap_up();
  end
  initial
  begin
    #20000;
    err_total++;
    wrap_up();
  end
endmodule // tb
bind fbcw_top fbcw_chk i_chk
(
  .clk (clk), .sys_rst (sys_rst), .cw_valid (cw_valid),
  .drive_command_word (drive_command_word), .control_place_is_bus (control_place_is_bus),
  .motor_zero_speed (motor_zero_speed), .fault_in (fault_in), .warning_in (warning_in),
  .drive_state_word (drive_state_word), .run_cmd_q (run_cmd_q), .ramp_mode_q (ramp_mode_q),
  .jog1_sel_q (jog1_sel_q), .jog2_sel_q (jog2_sel_q), .fault_ack_q (fault_ack_q)
);

// [hdl/fbcw_heartbeat.v]
// heartbeat supervisor for the link heartbeat bit of the command word
// assumes word updates are one-cycle strobes on the drive clock
`timescale 1ns/1ps
`include "fbcw_regs.vh"
module fbcw_heartbeat
#(
  parameter TICK_CYC = `FBCW_TICK_CYC
)
(
  input  wire        clk,
  input  wire        sys_rst,
  input  wire        word_valid,
  input  wire        link_heartbeat,
  input  wire [15:0] heartbeat_timeout_setting,
  output reg         heartbeat_lost_q
);
  reg        hb_last_q;
  reg [31:0] tick_cnt_q;
  reg [15:0] ms_cnt_q;
  wire       toggled;
  wire       tick;

  assign toggled = word_valid && (link_heartbeat != hb_last_q);
  assign tick    = (tick_cnt_q == TICK_CYC - 1);

  // *****************************************************
  // silence timer, restarted by every heartbeat toggle
  // *****************************************************
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      hb_last_q        <= 1'b0;
      tick_cnt_q       <= 32'h00000000;
      ms_cnt_q         <= 16'h0000;
      heartbeat_lost_q <= 1'b0;
    end
    else
    begin
      if (word_valid)
        hb_last_q <= link_heartbeat;
      // zero setting disables supervision entirely
      if (heartbeat_timeout_setting == 16'h0000 || toggled)
      begin
        tick_cnt_q       <= 32'h00000000;
        ms_cnt_q         <= 16'h0000;
        heartbeat_lost_q <= 1'b0;                               // RULE_17
      end
      else
      begin
        tick_cnt_q <= tick ? 32'h00000000 : tick_cnt_q + 32'h00000001;
        if (tick && ms_cnt_q != 16'hFFFF)
          ms_cnt_q <= ms_cnt_q + 16'h0001;
        if (ms_cnt_q >= heartbeat_timeout_setting)
          heartbeat_lost_q <= 1'b1;                             // RULE_17
      end
    end
  end
endmodule // fbcw_heartbeat

// [hdl/fbcw_top.v]
// fieldbus drive control word interpreter and state word generator
// assumes the command word arrives whole with a one-cycle update strobe,
// and that motor-side status inputs are synchronous to clk
`timescale 1ns/1ps
`include "fbcw_regs.vh"
// What this block does
// [RULE_01] on edge clears inhibit, enters ready-to-run
// [RULE_02] on low gives ramped stop, ready-to-switch-on
// [RULE_03] coast bit low coasts, enters inhibit
// [RULE_04] quick-stop bit low runs quick stop
// [RULE_05] run bit starts or stops drive
// [RULE_06] ramp-enable low zeroes ramp output, top priority
// [RULE_07] ramp-unhold low freezes ramp output
// [RULE_08] setpoint-enable low zeroes reference, lowest priority
// [RULE_09] fault-ack edge clears faults, maybe inhibit
// [RULE_10] bus jog: run with ramp bits zero
// [RULE_11] ramp bits honoured after jog stops at zero
// [RULE_12] jog bits follow jog refs when enabled
// [RULE_13] both jog requests together means stop
// [RULE_14] jog ignored while run is active
// [RULE_15] io jog starts drive when jog-enabled
// [RULE_16] bus-enable bit gates; withdrawal coasts
// [RULE_17] heartbeat loss faults unless timeout zero
// [RULE_18] state bits 0..10 report drive status
// [RULE_19] bit 15 echoes heartbeat; 11..14 zero
// [RULE_20] inhibit clears only after releases then on
// [RULE_21] whole word sampled at once; 12..15 ignored
// [RULE_22] edges found against previous received word
module fbcw_top
(
  input  wire        clk,
  input  wire        sys_rst,
  input  wire        cw_valid,
  input  wire [15:0] drive_command_word,
  input  wire [15:0] heartbeat_timeout_setting,
  input  wire        control_place_is_bus,
  input  wire        aux_jog_enable,
  input  wire        jog_enable_din,
  input  wire        io_jog1,
  input  wire        io_jog2,
  input  wire        motor_zero_speed,
  input  wire        modulating,
  input  wire        fault_in,
  input  wire        fault_removed_voltage,
  input  wire        warning_in,
  input  wire        speed_at_ref,
  input  wire        fout_above_fmax,
  output reg  [15:0] drive_state_word,
  output reg         run_cmd_q,
  output reg  [1:0]  stop_kind_q,
  output reg  [1:0]  ramp_mode_q,
  output reg         jog1_sel_q,
  output reg         jog2_sel_q,
  output reg         fault_ack_q
);
  // drive states
  localparam [2:0] ST_INHIBIT  = 3'h0;
  localparam [2:0] ST_RDY_ON   = 3'h1;
  localparam [2:0] ST_RDY_OP   = 3'h2;
  localparam [2:0] ST_RUN      = 3'h3;
  localparam [2:0] ST_FAULT    = 3'h4;

  reg  [15:0] cw_q;
  reg         bus_coast_q;
  reg  [2:0]  state_q;
  reg  [2:0]  state_d;
  reg         fault_q;
  reg         jog_active_q;
  reg         jog_hold_q;
  reg         on_edge_q;
  reg         fack_edge_q;
  wire        hb_lost;
  wire        bus_ok;
  wire        on_b;
  wire        coast_n;
  wire        qstop_n;
  wire        run_b;
  wire        ramp_bits_zero;
  wire        jog1_req;
  wire        jog2_req;
  wire        io_jog_req;
  wire        bus_jog_req;

  // returns 1 when bit goes 0 to 1 between words
  function rise;
    input prev_bit;
    input cur_bit;
    begin
      rise = cur_bit & ~prev_bit;
    end
  endfunction

  // *****************************************************
  // command word capture
  // *****************************************************
  // capture the whole word in one edge so bits never mix across updates
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cw_q        <= `FBCW_CW_RESET;
      on_edge_q   <= 1'b0;
      fack_edge_q <= 1'b0;
    end
    else
    begin
      on_edge_q   <= 1'b0;
      fack_edge_q <= 1'b0;
      if (cw_valid)
      begin
        cw_q      <= {4'h0, drive_command_word[11:0]};               // RULE_21
        on_edge_q <= rise(cw_q[`FBCW_CW_ON],
                          drive_command_word[`FBCW_CW_ON]);          // RULE_22
        fack_edge_q <= rise(cw_q[`FBCW_CW_FACK],
                            drive_command_word[`FBCW_CW_FACK]);      // RULE_22
      end
    end
  end

  fbcw_heartbeat u_heartbeat
  (
    .clk                       (clk),
    .sys_rst                   (sys_rst),
    .word_valid                (cw_valid),
    .link_heartbeat            (drive_command_word[`FBCW_CW_HBEAT]),
    .heartbeat_timeout_setting (heartbeat_timeout_setting),
    .heartbeat_lost_q          (hb_lost)
  );

  // *****************************************************
  // decoded requests
  // *****************************************************
  // without bus control the on, coast, quick-stop, run and jog bits are disregarded; releases read as active
  assign bus_ok         = cw_q[`FBCW_CW_FB_EN] & control_place_is_bus;   // RULE_16
  assign on_b           = bus_ok & cw_q[`FBCW_CW_ON];
  assign coast_n        = cw_q[`FBCW_CW_COAST_N] | ~bus_ok;
  assign qstop_n        = cw_q[`FBCW_CW_QSTOP_N] | ~bus_ok;
  assign run_b          = bus_ok & cw_q[`FBCW_CW_RUN];
  assign ramp_bits_zero = ~cw_q[`FBCW_CW_RAMP_EN] & ~cw_q[`FBCW_CW_RAMP_UNHOLD]
                          & ~cw_q[`FBCW_CW_SETP_EN];
  assign bus_jog_req    = run_b & ramp_bits_zero;                     // RULE_10
  // jog bits need an enable and are ignored under a plain run command
  assign jog1_req = bus_ok & cw_q[`FBCW_CW_JOG1] & aux_jog_enable & ~run_b;   // RULE_12 RULE_14
  assign jog2_req = bus_ok & cw_q[`FBCW_CW_JOG2] & aux_jog_enable & ~run_b;   // RULE_12 RULE_14
  assign io_jog_req = jog_enable_din & (io_jog1 ^ io_jog2);           // RULE_15

  // *****************************************************
  // fault latch
  // *****************************************************
  // new faults win over an acknowledge in the same cycle
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      fault_q <= 1'b0;
    else if (fault_in || hb_lost)
      fault_q <= 1'b1;                                                // RULE_17
    else if (fack_edge_q)
      fault_q <= 1'b0;                                                // RULE_09
  end

  // *****************************************************
  // switch-on state machine
  // *****************************************************
  always @*
  begin
    state_d = state_q;
    case (state_q)
      ST_FAULT:
      begin
        if (!fault_q)
          state_d = fault_removed_voltage ? ST_INHIBIT : ST_RDY_ON;   // RULE_09
      end
      ST_INHIBIT:
      begin
        // releases first, then a fresh on edge
        if (coast_n && qstop_n && on_edge_q && bus_ok)
          state_d = ST_RDY_OP;                                        // RULE_01 RULE_20
      end
      ST_RDY_ON:
      begin
        if (on_edge_q && bus_ok && coast_n && qstop_n)
          state_d = ST_RDY_OP;                                        // RULE_01
      end
      ST_RDY_OP:
      begin
        if (!on_b)
          state_d = ST_RDY_ON;                                        // RULE_02
        else if (run_b && (!bus_jog_req || motor_zero_speed))
          state_d = ST_RUN;                                           // RULE_05 RULE_10
      end
      ST_RUN:
      begin
        if (!on_b)
          state_d = ST_RDY_ON;                                        // RULE_02
        else if (!run_b)
          state_d = ST_RDY_OP;                                        // RULE_05
      end
      default:
        state_d = ST_INHIBIT;
    endcase
    // coast and quick stop override any run state
    if (state_q != ST_FAULT && (!coast_n || !qstop_n))
      state_d = ST_INHIBIT;                                           // RULE_03 RULE_04
    if (state_q != ST_FAULT && state_q != ST_INHIBIT && !bus_ok)
      state_d = ST_INHIBIT;                                           // RULE_16
    if (fault_q && state_q != ST_FAULT)
      state_d = ST_FAULT;
  end

  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      state_q <= ST_INHIBIT;
    else
      state_q <= state_d;
  end

  // *****************************************************
  // jog tracking
  // *****************************************************
  // ramp bits stay masked after a jog until the motor is at rest
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      jog_active_q <= 1'b0;
      jog_hold_q   <= 1'b0;
    end
    else
    begin
      jog_active_q <= (state_q == ST_RUN) & bus_jog_req;
      if (jog_active_q && !bus_jog_req)
        jog_hold_q <= 1'b1;                                           // RULE_11
      else if (motor_zero_speed)
        jog_hold_q <= 1'b0;                                           // RULE_11
    end
  end

  // a withdrawn bus keeps the coast request until control comes back
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      bus_coast_q <= 1'b0;
    else if (bus_ok)
      bus_coast_q <= 1'b0;
    else if (state_q != ST_INHIBIT && state_q != ST_FAULT)
      bus_coast_q <= 1'b1;                                            // RULE_16
  end

  // *****************************************************
  // drive command outputs
  // *****************************************************
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      run_cmd_q   <= 1'b0;
      stop_kind_q <= `FBCW_STOP_NONE;
      ramp_mode_q <= `FBCW_RAMP_TRACK;
      jog1_sel_q  <= 1'b0;
      jog2_sel_q  <= 1'b0;
      fault_ack_q <= 1'b0;
    end
    else
    begin
      fault_ack_q <= fack_edge_q;                                     // RULE_09
      // both jog inputs at once count as a stop request
      jog1_sel_q  <= (jog1_req & ~jog2_req) | (jog_enable_din & io_jog1 & ~io_jog2); // RULE_13
      jog2_sel_q  <= (jog2_req & ~jog1_req) | (jog_enable_din & io_jog2 & ~io_jog1); // RULE_13
      run_cmd_q   <= (state_d == ST_RUN) | io_jog_req
                     | (state_d == ST_RDY_OP & (jog1_req ^ jog2_req)); // RULE_15 RULE_12
      if (fault_q || !coast_n || bus_coast_q
          || (state_q != ST_INHIBIT && state_q != ST_FAULT && !bus_ok))
        stop_kind_q <= `FBCW_STOP_COAST;                              // RULE_03 RULE_16
      else if (!qstop_n)
        stop_kind_q <= `FBCW_STOP_QUICK;                              // RULE_04
      else if (!on_b || !run_b)
        stop_kind_q <= `FBCW_STOP_RAMP;                               // RULE_02 RULE_05
      else
        stop_kind_q <= `FBCW_STOP_NONE;
      // fixed priority: zero output, then hold, then zero input
      if (jog_active_q || jog_hold_q)
        ramp_mode_q <= `FBCW_RAMP_TRACK;                              // RULE_11
      else if (!cw_q[`FBCW_CW_RAMP_EN])
        ramp_mode_q <= `FBCW_RAMP_ZERO_OUT;                           // RULE_06
      else if (!cw_q[`FBCW_CW_RAMP_UNHOLD])
        ramp_mode_q <= `FBCW_RAMP_HOLD;                               // RULE_07
      else if (!cw_q[`FBCW_CW_SETP_EN])
        ramp_mode_q <= `FBCW_RAMP_ZERO_IN;                            // RULE_08
      else
        ramp_mode_q <= `FBCW_RAMP_TRACK;
    end
  end

  // *****************************************************
  // state word
  // *****************************************************
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      drive_state_word <= `FBCW_SW_RESET;
    else
    begin
      drive_state_word <= 16'h0000;
      drive_state_word[`FBCW_SW_RDY_ON]    <= (state_q == ST_RDY_ON) | (state_q == ST_RDY_OP)
                                              | (state_q == ST_RUN);   // RULE_18
      drive_state_word[`FBCW_SW_RDY_OP]    <= (state_q == ST_RDY_OP) | (state_q == ST_RUN);
      drive_state_word[`FBCW_SW_RUNNING]   <= (state_q == ST_RUN) & modulating;
      drive_state_word[`FBCW_SW_FAULT]     <= fault_q;
      drive_state_word[`FBCW_SW_NO_COAST]  <= coast_n;
      drive_state_word[`FBCW_SW_NO_QSTOP]  <= qstop_n;
      drive_state_word[`FBCW_SW_INHIBIT]   <= (state_q == ST_INHIBIT);  // RULE_20
      drive_state_word[`FBCW_SW_WARN]      <= warning_in;
      drive_state_word[`FBCW_SW_AT_REF]    <= speed_at_ref;
      drive_state_word[`FBCW_SW_FB_ACT]    <= bus_ok;
      drive_state_word[`FBCW_SW_OVER_FMAX] <= fout_above_fmax;
      drive_state_word[`FBCW_SW_HBEAT]     <= cw_q[`FBCW_CW_HBEAT];     // RULE_19
    end
  end
endmodule // fbcw_top

// [include/fbcw_regs.vh]
// constants for the fieldbus drive control word interpreter
// assumes a 16-bit command word and a 16-bit state word, one drive clock
`ifndef FBCW_REGS_VH
`define FBCW_REGS_VH
// command word bit positions
`define FBCW_CW_ON          0
`define FBCW_CW_COAST_N     1
`define FBCW_CW_QSTOP_N     2
`define FBCW_CW_RUN         3
`define FBCW_CW_RAMP_EN     4
`define FBCW_CW_RAMP_UNHOLD 5
`define FBCW_CW_SETP_EN     6
`define FBCW_CW_FACK        7
`define FBCW_CW_JOG1        8
`define FBCW_CW_JOG2        9
`define FBCW_CW_FB_EN       10
`define FBCW_CW_HBEAT       11
// state word bit positions
`define FBCW_SW_RDY_ON      0
`define FBCW_SW_RDY_OP      1
`define FBCW_SW_RUNNING     2
`define FBCW_SW_FAULT       3
`define FBCW_SW_NO_COAST    4
`define FBCW_SW_NO_QSTOP    5
`define FBCW_SW_INHIBIT     6
`define FBCW_SW_WARN        7
`define FBCW_SW_AT_REF      8
`define FBCW_SW_FB_ACT      9
`define FBCW_SW_OVER_FMAX   10
`define FBCW_SW_HBEAT       15
// reset values
`define FBCW_CW_RESET       16'h0000
`define FBCW_SW_RESET       16'h0040
// heartbeat timeout unit: one tick = 1 ms at 250 MHz clock
`define FBCW_TICK_NS        1000000
`define FBCW_CLK_NS         4
`define FBCW_TICK_CYC       (`FBCW_TICK_NS / `FBCW_CLK_NS)
// ramp command encoding
`define FBCW_RAMP_TRACK     2'h0
`define FBCW_RAMP_ZERO_OUT  2'h1
`define FBCW_RAMP_HOLD      2'h2
`define FBCW_RAMP_ZERO_IN   2'h3
// stop kinds
`define FBCW_STOP_NONE      2'h0
`define FBCW_STOP_RAMP      2'h1
`define FBCW_STOP_COAST     2'h2
`define FBCW_STOP_QUICK     2'h3
`endif
